// ### hub_remap_pkg.sv
// Register map and field layout of the pin polarity and port remap bank
package hub_remap_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_SWAP      = 10'h0FA;
    localparam logic [9:0] IDX_REMAP12   = 10'h0FB;
    localparam logic [9:0] IDX_CTRL      = 10'h0FC;
    localparam logic [9:0] IDX_STATUS    = 10'h0FD;

    // APB address width and word alignment
    localparam int unsigned ADDR_W       = 12;
    localparam logic [1:0]  ALIGN_OK     = 2'h0;

    // Values after reset
    localparam logic [7:0]  SWAP_RESET   = 8'h00;
    localparam logic [7:0]  REMAP_RESET  = 8'h00;
    localparam logic        ENABLE_RESET = 1'b0;

    // Swap register: bit 0 upstream, bit n downstream port n
    localparam int unsigned SWAP_UP_BIT  = 0;

    // Remap register fields
    localparam int unsigned FIELD_W      = 4;
    localparam int unsigned P1_LSB       = 0;
    localparam int unsigned P2_LSB       = 4;
    localparam logic [3:0]  LOG_DISABLED = 4'h0;
    localparam int unsigned RESERVED_BIT = 3;

    // Control register: remap mode enable
    localparam int unsigned CTRL_EN_BIT  = 0;

    // Status register layout
    localparam int unsigned ST_LOG1_LSB  = 0;
    localparam int unsigned ST_LOG2_LSB  = 4;
    localparam int unsigned ST_PEN_LSB   = 8;
    localparam int unsigned ST_CNT_LSB   = 16;

endpackage

// ### pin_pair_swap.sv
`timescale 1ns/100ps
`default_nettype none

// Steers one plus/minus pin pair; purely combinational so USB
// signalling picks up no clock latency through the swap
module pin_pair_swap (
    input  wire logic swap,
    input  wire logic core_plus_tx,
    input  wire logic core_minus_tx,
    input  wire logic core_tx_oe,
    output logic      core_plus_rx,
    output logic      core_minus_rx,
    input  wire logic usb_plus_pin_i,
    output logic      usb_plus_pin_o,
    output logic      usb_plus_pin_oe,
    input  wire logic usb_minus_pin_i,
    output logic      usb_minus_pin_o,
    output logic      usb_minus_pin_oe
);

    // Transmit side: straight or crossed
    always_comb begin
        if (swap) begin
            usb_plus_pin_o  = core_minus_tx;
            usb_minus_pin_o = core_plus_tx;
        end else begin
            usb_plus_pin_o  = core_plus_tx;
            usb_minus_pin_o = core_minus_tx;
        end
        usb_plus_pin_oe  = core_tx_oe;
        usb_minus_pin_oe = core_tx_oe;
    end

    // Receive side mirrors the transmit crossing
    always_comb begin
        if (swap) begin
            core_plus_rx  = usb_minus_pin_i;
            core_minus_rx = usb_plus_pin_i;
        end else begin
            core_plus_rx  = usb_plus_pin_i;
            core_minus_rx = usb_minus_pin_i;
        end
    end

endmodule

`default_nettype wire

// ### hub_port_swap_remap_config.sv
`timescale 1ns/100ps
`default_nettype none

module hub_port_swap_remap_config #(
    parameter int unsigned NUM_DS = 7
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [hub_remap_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [31:0]                          pwdata,
    input  wire logic [3:0]                           pstrb,
    output logic      [31:0]                          prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic                                 remap_mode_enable,
    input  wire logic [NUM_DS:0]                      core_plus_tx,
    input  wire logic [NUM_DS:0]                      core_minus_tx,
    input  wire logic [NUM_DS:0]                      core_tx_oe,
    output logic      [NUM_DS:0]                      core_plus_rx,
    output logic      [NUM_DS:0]                      core_minus_rx,
    input  wire logic [NUM_DS:0]                      usb_plus_pin_i,
    output logic      [NUM_DS:0]                      usb_plus_pin_o,
    output logic      [NUM_DS:0]                      usb_plus_pin_oe,
    input  wire logic [NUM_DS:0]                      usb_minus_pin_i,
    output logic      [NUM_DS:0]                      usb_minus_pin_o,
    output logic      [NUM_DS:0]                      usb_minus_pin_oe,
    output logic      [NUM_DS:1][3:0]                 logical_port_num,
    output logic      [NUM_DS:1]                      port_enabled,
    output logic      [3:0]                           reported_port_count,
    output logic      [7:0]                           pin_polarity_swap_bits,
    output logic      [7:0]                           remap_field_ports_one_two
);

    // Whole register state of the block
    typedef struct packed {
        logic [7:0]            swap;
        logic [7:0]            remap;
        logic                  en_sw;
        logic [31:0]           rdata;
        logic [NUM_DS:1][3:0]  logical;
        logic [NUM_DS:1]       pen;
        logic [3:0]            count;
    } state_s;

    state_s      s_q;
    state_s      s_d;
    logic        setup_ph;
    logic        access_ph;
    logic [9:0]  idx;
    logic        mapped;
    logic        wr_en;
    logic        remap_on;

    // Reserved codes fall back to the disabled code
    function automatic logic [3:0] decode_field(input logic [3:0] f);
        if (f[hub_remap_pkg::RESERVED_BIT]) begin
            decode_field = hub_remap_pkg::LOG_DISABLED;
        end else begin
            decode_field = f;
        end
    endfunction

    // APB phase and address decode; misaligned words count as unmapped
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign idx       = paddr[hub_remap_pkg::ADDR_W-1:2];
    assign mapped    = (paddr[1:0] == hub_remap_pkg::ALIGN_OK) &&
                       ((idx == hub_remap_pkg::IDX_SWAP)   ||
                        (idx == hub_remap_pkg::IDX_REMAP12) ||
                        (idx == hub_remap_pkg::IDX_CTRL)   ||
                        (idx == hub_remap_pkg::IDX_STATUS));
    assign wr_en     = access_ph & pwrite & mapped & pstrb[0];

    // Either the pin-level enable or the software copy turns remapping on
    assign remap_on  = remap_mode_enable | s_q.en_sw;

    // Next-state logic for the whole bank
    always_comb begin
        logic [3:0] cnt;
        cnt = 4'h0;
        s_d = s_q;

        // Read data is captured in setup so it leaves a flop in access
        if (setup_ph && !pwrite) begin
            s_d.rdata = 32'h0000_0000;
            if (paddr[1:0] == hub_remap_pkg::ALIGN_OK) begin
                case (idx)
                    hub_remap_pkg::IDX_SWAP:    s_d.rdata[7:0] = s_q.swap;
                    hub_remap_pkg::IDX_REMAP12: s_d.rdata[7:0] = s_q.remap;
                    hub_remap_pkg::IDX_CTRL:    s_d.rdata[hub_remap_pkg::CTRL_EN_BIT] = s_q.en_sw;
                    hub_remap_pkg::IDX_STATUS: begin
                        s_d.rdata[hub_remap_pkg::ST_LOG1_LSB +: 4]      = s_q.logical[1];
                        s_d.rdata[hub_remap_pkg::ST_LOG2_LSB +: 4]      = s_q.logical[2];
                        s_d.rdata[hub_remap_pkg::ST_PEN_LSB +: NUM_DS]  = s_q.pen;
                        s_d.rdata[hub_remap_pkg::ST_CNT_LSB +: 4]       = s_q.count;
                    end
                    default:                    s_d.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Writes land only on the access edge; only byte lane 0 is wired
        if (wr_en) begin
            case (idx)
                hub_remap_pkg::IDX_SWAP:    s_d.swap  = pwdata[7:0];
                hub_remap_pkg::IDX_REMAP12: s_d.remap = pwdata[7:0];
                hub_remap_pkg::IDX_CTRL:    s_d.en_sw = pwdata[hub_remap_pkg::CTRL_EN_BIT];
                default:                    s_d.en_sw = s_q.en_sw;
            endcase
        end

        // Physical to logical numbering, one cycle behind the registers
        for (int p = 1; p <= int'(NUM_DS); p++) begin
            s_d.logical[p] = 4'(p);
            if (remap_on && p == 1) begin
                s_d.logical[p] = decode_field(s_q.remap[hub_remap_pkg::P1_LSB +: hub_remap_pkg::FIELD_W]);
            end
            if (remap_on && p == 2) begin
                s_d.logical[p] = decode_field(s_q.remap[hub_remap_pkg::P2_LSB +: hub_remap_pkg::FIELD_W]);
            end
            s_d.pen[p] = (s_d.logical[p] != hub_remap_pkg::LOG_DISABLED);
            cnt = cnt + 4'(s_d.pen[p]);
        end

        // Only the count goes to enumeration; the host picks the numbers
        s_d.count = cnt;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.swap    <= hub_remap_pkg::SWAP_RESET;
            s_q.remap   <= hub_remap_pkg::REMAP_RESET;
            s_q.en_sw   <= hub_remap_pkg::ENABLE_RESET;
            s_q.rdata   <= 32'h0000_0000;
            s_q.logical <= '0;
            s_q.pen     <= '0;
            s_q.count   <= 4'h0;
        end else begin
            s_q <= s_d;
        end
    end

    // Zero-wait slave; unmapped or misaligned access is flagged
    assign pready  = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign prdata  = s_q.rdata;

    assign logical_port_num          = s_q.logical;
    assign port_enabled              = s_q.pen;
    assign reported_port_count       = s_q.count;
    assign pin_polarity_swap_bits    = s_q.swap;
    assign remap_field_ports_one_two = s_q.remap;

    // One swapper per pin pair; index 0 is the upstream port
    for (genvar g = 0; g <= int'(NUM_DS); g++) begin : g_pair
        pin_pair_swap u_pair (
            .swap             (s_q.swap[g]),
            .core_plus_tx     (core_plus_tx[g]),
            .core_minus_tx    (core_minus_tx[g]),
            .core_tx_oe       (core_tx_oe[g]),
            .core_plus_rx     (core_plus_rx[g]),
            .core_minus_rx    (core_minus_rx[g]),
            .usb_plus_pin_i   (usb_plus_pin_i[g]),
            .usb_plus_pin_o   (usb_plus_pin_o[g]),
            .usb_plus_pin_oe  (usb_plus_pin_oe[g]),
            .usb_minus_pin_i  (usb_minus_pin_i[g]),
            .usb_minus_pin_o  (usb_minus_pin_o[g]),
            .usb_minus_pin_oe (usb_minus_pin_oe[g])
        );
    end

    // Checks, all in the pclk domain
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Unswapped pairs pass plus to plus
    property p_straight;
        ((usb_plus_pin_o ^ core_plus_tx) & ~s_q.swap) == '0;
    endproperty
    a_straight: assert property (p_straight) else $error("unswapped pair misroutes plus");

    // Swapped pairs carry plus on the minus pin
    property p_crossed;
        ((usb_minus_pin_o ^ core_plus_tx) & s_q.swap) == '0;
    endproperty
    a_crossed: assert property (p_crossed) else $error("swapped pair misroutes plus");

    // A swap write shows on all eight swap controls, upstream included, at the next edge
    property p_swap_write;
        wr_en && idx == hub_remap_pkg::IDX_SWAP |=> pin_polarity_swap_bits == $past(pwdata[7:0]);
    endproperty
    a_swap_write: assert property (p_swap_write) else $error("swap register not updated");

    // Upstream receive follows bit 0
    property p_upstream;
        core_plus_rx[0] == (s_q.swap[0] ? usb_minus_pin_i[0] : usb_plus_pin_i[0]);
    endproperty
    a_upstream: assert property (p_upstream) else $error("upstream pair ignores bit 0");

    // With remapping off for three cycles, port 2 keeps its own number; the first cycle spans reset release
    property p_identity;
        (!remap_on) [*3] |-> logical_port_num[2] == 4'h2 && port_enabled[2];
    endproperty
    a_identity: assert property (p_identity) else $error("numbers changed while remap off");

    // Zero code disables physical port 2
    property p_p2_off;
        remap_on && s_q.remap[7:4] == 4'h0 |=> !port_enabled[2];
    endproperty
    a_p2_off: assert property (p_p2_off) else $error("port 2 not disabled by zero code");

    // Codes one to seven are the logical number itself
    property p_p2_map;
        remap_on && s_q.remap[7:4] != 4'h0 && !s_q.remap[7] |=> logical_port_num[2] == $past(s_q.remap[7:4]);
    endproperty
    a_p2_map: assert property (p_p2_map) else $error("port 2 logical number wrong");

    // Reserved codes act as disabled
    property p_p2_rsv;
        remap_on && s_q.remap[7] |=> logical_port_num[2] == 4'h0 && !port_enabled[2];
    endproperty
    a_p2_rsv: assert property (p_p2_rsv) else $error("reserved code not treated as zero");

    // Low field maps physical port 1 the same way
    property p_p1_map;
        remap_on |=> logical_port_num[1] == ($past(s_q.remap[3]) ? 4'h0 : $past(s_q.remap[3:0]));
    endproperty
    a_p1_map: assert property (p_p1_map) else $error("port 1 logical number wrong");

    // Reported count matches the enabled ports
    property p_count;
        reported_port_count == 4'($countones(port_enabled));
    endproperty
    a_count: assert property (p_count) else $error("reported count mismatch");

    // Unswapped pairs pass minus to minus
    property p_minus_straight;
        ((usb_minus_pin_o ^ core_minus_tx) & ~s_q.swap) == '0;
    endproperty
    a_minus_straight: assert property (p_minus_straight) else $error("unswapped pair misroutes minus");

    // Swapped pairs carry minus on the plus pin
    property p_minus_crossed;
        ((usb_plus_pin_o ^ core_minus_tx) & s_q.swap) == '0;
    endproperty
    a_minus_crossed: assert property (p_minus_crossed) else $error("swapped pair misroutes minus");

    // Receive path stays straight on unswapped pairs
    property p_rx_straight;
        ((core_plus_rx ^ usb_plus_pin_i) & ~s_q.swap) == '0 && ((core_minus_rx ^ usb_minus_pin_i) & ~s_q.swap) == '0;
    endproperty
    a_rx_straight: assert property (p_rx_straight) else $error("unswapped pair misroutes receive");

    // Receive path is crossed on swapped pairs
    property p_rx_crossed;
        ((core_plus_rx ^ usb_minus_pin_i) & s_q.swap) == '0 && ((core_minus_rx ^ usb_plus_pin_i) & s_q.swap) == '0;
    endproperty
    a_rx_crossed: assert property (p_rx_crossed) else $error("swapped pair misroutes receive");

    // A remap write holds both fields from the next edge
    property p_remap_write;
        wr_en && idx == hub_remap_pkg::IDX_REMAP12 |=> remap_field_ports_one_two == $past(pwdata[7:0]);
    endproperty
    a_remap_write: assert property (p_remap_write) else $error("remap register not updated");

    // Zero code in the low field disables physical port 1
    property p_p1_off;
        remap_on && s_q.remap[3:0] == 4'h0 |=> !port_enabled[1];
    endproperty
    a_p1_off: assert property (p_p1_off) else $error("port 1 not disabled by zero code");

    // Ports 3..7 have no remap field, so they keep their own numbers once out of reset
    property p_fixed_ports;
        $past(presetn) |-> logical_port_num[7:3] == {4'h7, 4'h6, 4'h5, 4'h4, 4'h3} && port_enabled[7:3] == 5'h1F;
    endproperty
    a_fixed_ports: assert property (p_fixed_ports) else $error("unremapped port numbers changed");

    // Main scenarios
    c_swap_write: cover property (wr_en && idx == hub_remap_pkg::IDX_SWAP);
    c_remap_on:   cover property (remap_on ##1 !port_enabled[2]);
    c_reserved:   cover property (remap_on && s_q.remap[7]);
    c_slverr:     cover property (pslverr);
    c_p1_off:     cover property (remap_on && s_q.remap[3:0] == 4'h0);

endmodule

`default_nettype wire

// ### hub_far_end_model.sv
`timescale 1ns/100ps
`default_nettype none

// Far side of the pin pairs: drives the true differential pair when asked
module hub_far_end_model (
    input  wire logic [7:0] plus_o,
    input  wire logic [7:0] plus_oe,
    input  wire logic [7:0] minus_o,
    input  wire logic [7:0] minus_oe,
    input  wire logic [7:0] far_level,
    input  wire logic       far_drive,
    input  wire logic [3:0] port_count,
    output logic      [7:0] plus_i,
    output logic      [7:0] minus_i,
    output logic      [3:0] host_last_num
);
    // Design drive wins; released wires sink to the pull-down, not the last value
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            plus_i[n] = plus_oe[n] ? plus_o[n] : (far_drive & far_level[n]);
            minus_i[n] = minus_oe[n] ? minus_o[n] : (far_drive & ~far_level[n]);
        end
    end

    // Host numbers ports one up to the reported count
    assign host_last_num = port_count;
endmodule

`default_nettype wire

// ### tb_hub_port_swap_remap_config.sv
`timescale 1ns/100ps
`default_nettype none

module tb_hub_port_swap_remap_config;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        remap_mode_enable = 1'b0;
    logic [7:0]  ptx = 8'hA5;
    logic [7:0]  mtx = 8'h5A;
    logic [7:0]  oe = 8'hFF;
    logic [7:0]  prx, mrx, pi, po, poe, mi, mo, moe, swap_bits, remap_bits;
    logic [7:0]  far_level = 8'h3C;
    logic [27:0] lnum;
    logic [7:1]  pen;
    logic [3:0]  cnt, host_last;
    int          miscompares = 0;
    int          n_checks = 0;

    always #50 pclk = ~pclk;

    hub_port_swap_remap_config i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .remap_mode_enable(remap_mode_enable), .core_plus_tx(ptx), .core_minus_tx(mtx),
        .core_tx_oe(oe), .core_plus_rx(prx), .core_minus_rx(mrx), .usb_plus_pin_i(pi), .usb_plus_pin_o(po),
        .usb_plus_pin_oe(poe), .usb_minus_pin_i(mi), .usb_minus_pin_o(mo), .usb_minus_pin_oe(moe),
        .logical_port_num(lnum), .port_enabled(pen), .reported_port_count(cnt),
        .pin_polarity_swap_bits(swap_bits), .remap_field_ports_one_two(remap_bits));

    hub_far_end_model i_far (.plus_o(po), .plus_oe(poe), .minus_o(mo), .minus_oe(moe), .far_level(far_level),
        .far_drive(1'b1), .port_count(cnt), .plus_i(pi), .minus_i(mi), .host_last_num(host_last));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; entered just after a rising edge, leaves a idle cycle behind
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, {idx, 2'h0}, {24'h0, d}, 4'hF, r, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 4'hF, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask

    // Ports 3..7 always keep their own number; codes with bit 3 set read as disabled
    function automatic logic [3:0] dec(input logic [3:0] c);
        return c[3] ? 4'h0 : c;
    endfunction

    task automatic chk_map(input logic [3:0] l2, input logic [3:0] l1);
        logic [1:0] e;
        e = {l2 != 4'h0, l1 != 4'h0};
        repeat (2) @(posedge pclk);
        chk({4'h0, lnum}, {12'h076, 4'h5, 4'h4, 4'h3, l2, l1});
        chk({25'h0, pen}, {25'h0, 5'h1F, e});
        chk({28'h0, cnt}, 32'd5 + e[1] + e[0]);
        chk({28'h0, host_last}, 32'd5 + e[1] + e[0]);
        rdc({hub_remap_pkg::IDX_STATUS, 2'h0}, {12'h0, 4'd5 + e[1] + e[0], 1'b0, 5'h1F, e, l2, l1}, 1'b0);
    endtask

    task automatic t_reset();
        rdc({hub_remap_pkg::IDX_SWAP, 2'h0}, 32'h0, 1'b0);
        rdc({hub_remap_pkg::IDX_REMAP12, 2'h0}, 32'h0, 1'b0);
        chk({4'h0, lnum}, 32'h0765_4321);
        chk({28'h0, cnt}, 32'h7);
        $display("test reset done");
    endtask

    // Each swap bit alone, then none: transmit and receive steering per pair
    task automatic t_swap();
        logic [7:0] s;
        for (int i = 0; i <= 8; i++) begin
            s = (i == 8) ? 8'h00 : 8'h01 << i;
            wr(hub_remap_pkg::IDX_SWAP, s);
            @(posedge pclk);
            chk({24'h0, po}, {24'h0, (ptx & ~s) | (mtx & s)});
            chk({24'h0, mo}, {24'h0, (mtx & ~s) | (ptx & s)});
            chk({16'h0, poe, moe}, 32'h0000_FFFF);
            chk({24'h0, swap_bits}, {24'h0, s});
            oe <= 8'h00;
            repeat (2) @(posedge pclk);
            chk({16'h0, prx, mrx}, {16'h0, far_level ^ s, ~far_level ^ s});
            oe <= 8'hFF;
            @(posedge pclk);
        end
        $display("test swap done");
    endtask

    // All sixteen codes in both fields, remap enabled by the pin
    task automatic t_remap();
        remap_mode_enable <= 1'b1;
        wr(hub_remap_pkg::IDX_REMAP12, 8'h12);
        chk_map(4'h1, 4'h2);
        for (int c = 0; c < 16; c++) begin
            wr(hub_remap_pkg::IDX_REMAP12, {c[3:0], ~c[3:0]});
            chk({24'h0, remap_bits}, {24'h0, c[3:0], ~c[3:0]});
            chk_map(dec(c[3:0]), dec(~c[3:0]));
        end
        $display("test remap done");
    endtask

    // Remap off gives identity; software enable alone turns it back on
    task automatic t_enable();
        remap_mode_enable <= 1'b0;
        chk_map(4'h2, 4'h1);
        wr(hub_remap_pkg::IDX_CTRL, 8'h01);
        rdc({hub_remap_pkg::IDX_CTRL, 2'h0}, 32'h1, 1'b0);
        chk_map(4'h0, 4'h0);
        wr(hub_remap_pkg::IDX_CTRL, 8'h00);
        chk_map(4'h2, 4'h1);
        $display("test enable done");
    endtask

    // Unmapped, misaligned, read-only and strobe-less accesses change nothing
    task automatic t_refuse();
        logic [31:0] r;
        logic        e;
        apb(1'b1, 12'h000, 32'hFF, 4'hF, r, e);
        chk({31'h0, e}, 32'h1);
        rdc(12'h000, 32'h0, 1'b1);
        rdc({hub_remap_pkg::IDX_SWAP, 2'h2}, 32'h0, 1'b1);
        apb(1'b1, {hub_remap_pkg::IDX_SWAP, 2'h0}, 32'hFF, 4'h0, r, e);
        wr(hub_remap_pkg::IDX_STATUS, 8'hFF);
        rdc({hub_remap_pkg::IDX_SWAP, 2'h0}, 32'h0, 1'b0);
        chk_map(4'h2, 4'h1);
        $display("test refuse done");
    endtask

    // Watchdog keeps a hung handshake from running forever
    initial begin
        #5_000_000;
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_swap();
        t_remap();
        t_enable();
        t_refuse();
        end_of_test();
    end
endmodule

`default_nettype wire
